//--- hdl/watchdog_pkg.sv
// watchdog downcounter constants: register indices, status layout, codes, reset values
// assumes an APB slave with 32-bit data and one aligned word per register
// Behaviour
// - counter runs on its own RC oscillator
// - only on or off; once on, never switches off
// - refresh or always-on option switches it on
// - 24-bit downcounter, reload from three bytes
// - period in ms is reload over ten
// - refresh ignored once count reached two
// - first switch-on loads reload, counts to zero
// - refresh reloads counter from reload value
// - debug mode refreshes continuously, no time-out
// - time-out at zero; option picks irq/reset
// - irq response: request plus time-out flag
// - after irq time-out roll to maximum
// - reset response, running: reset plus flag
// - reset response in stop: recovery, two flags
// - watchdog and oscillator run in stop default
// - 55,aa,81 disables in stop; 00 re-enables
// - unlock writes leave status bits unchanged
// - foreign write resets lock, blocks reload writes
// - reload byte reads return current count
// - control read clears upper four status bits
package watchdog_pkg;

    localparam int COUNT_W = 24;
    localparam int ADDR_W = 16;

    // printed offsets are not word multiples, so they are indices
    localparam logic [11:0] CTL_INDEX = 12'hff0;
    localparam logic [11:0] UPPER_INDEX = 12'hff1;
    localparam logic [11:0] HIGH_INDEX = 12'hff2;
    localparam logic [11:0] LOW_INDEX = 12'hff3;

    localparam logic [7:0] UNLOCK_FIRST = 8'h55;
    localparam logic [7:0] UNLOCK_SECOND = 8'haa;
    localparam logic [7:0] STOP_OFF_CODE = 8'h81;
    localparam logic [7:0] STOP_ON_CODE = 8'h00;

    localparam logic [23:0] RELOAD_RESET = 24'hffffff;
    localparam logic [23:0] COUNT_MAX = 24'hffffff;
    localparam logic [23:0] REFRESH_LIMIT = 24'h000002;
    localparam logic [23:0] MIN_RELOAD = 24'h000004;

    localparam int POR_BIT = 7;
    localparam int STOP_BIT = 6;
    localparam int TIMEOUT_BIT = 5;
    localparam int EXT_BIT = 4;
    localparam logic [7:0] STATUS_RESET = 8'h80;

    localparam int RC_TYPICAL_HZ = 10000;
    localparam int CLK_HZ = 100000000;
    localparam int RC_PERIOD_CYCLES = CLK_HZ / RC_TYPICAL_HZ;

    typedef enum logic [4:0] {
        LOCK_IDLE = 5'h01,
        LOCK_FIRST = 5'h02,
        LOCK_OPEN = 5'h04,
        LOCK_UPPER_DONE = 5'h08,
        LOCK_HIGH_DONE = 5'h10
    } lock_state_t;

    function automatic logic [ADDR_W-1:0] byte_addr(input logic [11:0] index);
        byte_addr = {2'b00, index, 2'b00};
    endfunction

endpackage

//--- hdl/rc_tick_sync.sv
// rising-edge detector for the free RC oscillator pin
// assumes the pin is asynchronous to CLK_IN and much slower than it
`timescale 1ns/1ps
module rc_tick_sync
    import watchdog_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // oscillator pin and one-cycle tick
    input wire logic rc_osc_in,
    output logic tick_out
);

    typedef struct packed {
        logic meta;
        logic sync;
        logic last;
        logic tick;
    } sync_state_t;

    sync_state_t state_reg;
    sync_state_t state_next;

    // first stage feeds only the second stage
    always_comb begin
        state_next = state_reg;
        state_next.meta = rc_osc_in;
        state_next.sync = state_reg.meta;
        state_next.last = state_reg.sync;
        state_next.tick = state_reg.sync & ~state_reg.last;
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign tick_out = state_reg.tick;

endmodule

//--- hdl/watchdog_downcounter.sv
// watchdog downcounter with APB register access and write-sequence lock
// assumes option bits, stop and debug mode come from logic on CLK_IN;
// the RC oscillator arrives as a pin and is synchronised here
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module watchdog_downcounter
    import watchdog_pkg::*;
(
    // clock and reset
    input wire logic CLK_IN,
    input wire logic RESET_IN,
    // apb slave
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [ADDR_W-1:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    // oscillator
    input wire logic RC_OSC_IN,
    output logic RC_OSC_ENABLE_OUT,
    // core, option bits and modes
    input wire logic REFRESH_IN,
    input wire logic ALWAYS_ON_IN,
    input wire logic RESPONSE_RESET_IN,
    input wire logic STOP_MODE_IN,
    input wire logic DEBUG_MODE_IN,
    input wire logic EXT_RESET_SEEN_IN,
    // time-out responses
    output logic TIMEOUT_IRQ_OUT,
    output logic TIMEOUT_RESET_OUT,
    output logic STOP_RECOVERY_OUT
);

    typedef struct packed {
        logic enabled;
        logic [COUNT_W-1:0] count;
        logic [COUNT_W-1:0] reload;
        logic stop_disable;
        logic [7:0] status;
        lock_state_t lock;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic irq;
        logic rst;
        logic recov;
        logic osc_en;
    } wd_state_t;

    wd_state_t state_reg;
    wd_state_t state_next;

    logic tick;
    logic [3:0] sel_setup;
    logic [3:0] sel_acc;
    logic acc;
    logic wr;
    logic rd_ctl;
    logic [7:0] wbyte;
    logic frozen;
    logic active;
    logic refresh_ok;
    logic timeout_ev;

    // one-hot: ctl, upper, high, low
    function automatic logic [3:0] decode(input logic [ADDR_W-1:0] addr);
        decode = 4'h0;
        if (addr == byte_addr(CTL_INDEX)) begin
            decode = 4'h1;
        end else if (addr == byte_addr(UPPER_INDEX)) begin
            decode = 4'h2;
        end else if (addr == byte_addr(HIGH_INDEX)) begin
            decode = 4'h4;
        end else if (addr == byte_addr(LOW_INDEX)) begin
            decode = 4'h8;
        end
    endfunction

    rc_tick_sync u_tick (
        .clk_in(CLK_IN),
        .reset_in(RESET_IN),
        .rc_osc_in(RC_OSC_IN),
        .tick_out(tick)
    );

    assign sel_setup = decode(PADDR_IN);
    assign sel_acc = decode(PADDR_IN);
    assign acc = PSEL_IN & PENABLE_IN & state_reg.pready;
    assign wr = acc & PWRITE_IN;
    assign rd_ctl = acc & ~PWRITE_IN & sel_acc[0];
    assign wbyte = PWDATA_IN[7:0];
    // the counter only halts when stop mode meets the stop-disable setting
    assign frozen = STOP_MODE_IN & state_reg.stop_disable;
    assign active = state_reg.enabled & ~frozen;
    // at or below two a refresh can no longer save it
    assign refresh_ok = REFRESH_IN & (state_reg.count > REFRESH_LIMIT);
    assign timeout_ev = active & ~DEBUG_MODE_IN & ~refresh_ok & tick
        & (state_reg.count == 24'h000001);

    always_comb begin
        state_next = state_reg;
        state_next.irq = 1'b0;
        state_next.rst = 1'b0;
        state_next.recov = 1'b0;
        state_next.osc_en = ~frozen;

        // counter
        if (!state_reg.enabled) begin
            if (REFRESH_IN || ALWAYS_ON_IN) begin
                state_next.enabled = 1'b1;
                state_next.count = state_reg.reload;
            end
        end else if (active) begin
            if (DEBUG_MODE_IN) begin
                state_next.count = state_reg.reload;
            end else if (refresh_ok) begin
                state_next.count = state_reg.reload;
            end else if (tick) begin
                if (state_reg.count == 24'h000000) begin
                    state_next.count = COUNT_MAX;
                end else begin
                    state_next.count = state_reg.count - 24'h000001;
                end
            end
        end

        // status: a read clears the upper nibble, events set after it so they win
        if (rd_ctl) begin
            state_next.status[7:4] = 4'h0;
        end
        if (EXT_RESET_SEEN_IN) begin
            state_next.status[EXT_BIT] = 1'b1;
        end
        if (timeout_ev) begin
            state_next.status[TIMEOUT_BIT] = 1'b1;
            if (!RESPONSE_RESET_IN) begin
                state_next.irq = 1'b1;
            end else if (STOP_MODE_IN) begin
                state_next.recov = 1'b1;
                state_next.status[STOP_BIT] = 1'b1;
                state_next.status[POR_BIT] = 1'b0;
            end else begin
                state_next.rst = 1'b1;
                state_next.status[STOP_BIT] = 1'b0;
                state_next.status[POR_BIT] = 1'b0;
            end
        end
        state_next.status[3:0] = 4'h0;

        // lock sequence; control writes never touch status
        if (wr) begin
            state_next.lock = LOCK_IDLE;
            case (state_reg.lock)
                LOCK_IDLE: begin
                    if (sel_acc[0] && wbyte == UNLOCK_FIRST) begin
                        state_next.lock = LOCK_FIRST;
                    end
                end
                LOCK_FIRST: begin
                    if (sel_acc[0] && wbyte == UNLOCK_SECOND) begin
                        state_next.lock = LOCK_OPEN;
                    end else if (sel_acc[0] && wbyte == UNLOCK_FIRST) begin
                        state_next.lock = LOCK_FIRST;
                    end
                end
                LOCK_OPEN: begin
                    if (sel_acc[0] && wbyte == STOP_OFF_CODE) begin
                        state_next.stop_disable = 1'b1;
                    end else if (sel_acc[0] && wbyte == STOP_ON_CODE) begin
                        state_next.stop_disable = 1'b0;
                    end else if (sel_acc[1]) begin
                        state_next.reload[23:16] = wbyte;
                        state_next.lock = LOCK_UPPER_DONE;
                    end else if (sel_acc[0] && wbyte == UNLOCK_FIRST) begin
                        state_next.lock = LOCK_FIRST;
                    end
                end
                LOCK_UPPER_DONE: begin
                    if (sel_acc[2]) begin
                        state_next.reload[15:8] = wbyte;
                        state_next.lock = LOCK_HIGH_DONE;
                    end else if (sel_acc[0] && wbyte == UNLOCK_FIRST) begin
                        state_next.lock = LOCK_FIRST;
                    end
                end
                LOCK_HIGH_DONE: begin
                    if (sel_acc[3]) begin
                        state_next.reload[7:0] = wbyte;
                    end else if (sel_acc[0] && wbyte == UNLOCK_FIRST) begin
                        state_next.lock = LOCK_FIRST;
                    end
                end
                default: begin
                    state_next.lock = LOCK_IDLE;
                end
            endcase
        end

        // apb: ready in the first access cycle, data prepared at setup
        state_next.pready = PSEL_IN & ~PENABLE_IN;
        state_next.pslverr = PSEL_IN & ~PENABLE_IN & (sel_setup == 4'h0);
        state_next.prdata = 32'h00000000;
        if (PSEL_IN && !PENABLE_IN && !PWRITE_IN) begin
            case (sel_setup)
                4'h1: state_next.prdata = {24'h000000, state_reg.status};
                4'h2: state_next.prdata = {24'h000000, state_reg.count[23:16]};
                4'h4: state_next.prdata = {24'h000000, state_reg.count[15:8]};
                4'h8: state_next.prdata = {24'h000000, state_reg.count[7:0]};
                default: state_next.prdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            state_reg.enabled <= 1'b0;
            state_reg.count <= RELOAD_RESET;
            state_reg.reload <= RELOAD_RESET;
            state_reg.stop_disable <= 1'b0;
            state_reg.status <= STATUS_RESET;
            state_reg.lock <= LOCK_IDLE;
            state_reg.pready <= 1'b0;
            state_reg.pslverr <= 1'b0;
            state_reg.prdata <= 32'h00000000;
            state_reg.irq <= 1'b0;
            state_reg.rst <= 1'b0;
            state_reg.recov <= 1'b0;
            state_reg.osc_en <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign PRDATA_OUT = state_reg.prdata;
    assign PREADY_OUT = state_reg.pready;
    assign PSLVERR_OUT = state_reg.pslverr;
    assign RC_OSC_ENABLE_OUT = state_reg.osc_en;
    assign TIMEOUT_IRQ_OUT = state_reg.irq;
    assign TIMEOUT_RESET_OUT = state_reg.rst;
    assign STOP_RECOVERY_OUT = state_reg.recov;

    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (RESET_IN);

    AST_DECREMENT: assert property (
        active && !DEBUG_MODE_IN && !refresh_ok && tick && state_reg.count != 24'h000000
        |=> state_reg.count == $past(state_reg.count) - 24'h000001)
        else $error("count did not drop by one on an oscillator tick");

    AST_HOLD_NO_TICK: assert property (
        state_reg.enabled && !tick && !REFRESH_IN && !DEBUG_MODE_IN
        |=> $stable(state_reg.count))
        else $error("count moved without an oscillator tick");

    AST_REFRESH_RELOAD: assert property (
        active && REFRESH_IN && state_reg.count > REFRESH_LIMIT
        |=> state_reg.count == $past(state_reg.reload))
        else $error("refresh did not reload the counter");

    AST_REFRESH_IGNORED: assert property (
        active && REFRESH_IN && !DEBUG_MODE_IN && !tick && state_reg.count <= REFRESH_LIMIT
        |=> state_reg.count == $past(state_reg.count))
        else $error("refresh accepted at or below two");

    AST_FIRST_ON: assert property (
        !state_reg.enabled && (REFRESH_IN || ALWAYS_ON_IN)
        |=> state_reg.enabled && state_reg.count == $past(state_reg.reload))
        else $error("switch-on did not load the reload value");

    AST_STAYS_ON: assert property (
        state_reg.enabled |=> state_reg.enabled)
        else $error("watchdog switched itself off");

    AST_DEBUG_NO_TIMEOUT: assert property (
        DEBUG_MODE_IN [*2] |-> !TIMEOUT_IRQ_OUT && !TIMEOUT_RESET_OUT && !STOP_RECOVERY_OUT)
        else $error("time-out response while debugging");

    AST_ROLLOVER: assert property (
        active && !DEBUG_MODE_IN && !REFRESH_IN && tick && state_reg.count == 24'h000000
        |=> state_reg.count == COUNT_MAX)
        else $error("counter did not roll over to maximum");

    AST_IRQ_RESPONSE: assert property (
        timeout_ev && !RESPONSE_RESET_IN
        |=> TIMEOUT_IRQ_OUT && state_reg.status[TIMEOUT_BIT] && !TIMEOUT_RESET_OUT ##1 !TIMEOUT_IRQ_OUT)
        else $error("interrupt time-out response wrong");

    AST_RESET_RESPONSE: assert property (
        timeout_ev && RESPONSE_RESET_IN && !STOP_MODE_IN
        |=> TIMEOUT_RESET_OUT && state_reg.status[TIMEOUT_BIT] && !state_reg.status[STOP_BIT])
        else $error("reset time-out response wrong");

    AST_STOP_RECOVERY: assert property (
        timeout_ev && RESPONSE_RESET_IN && STOP_MODE_IN
        |=> STOP_RECOVERY_OUT && state_reg.status[TIMEOUT_BIT] && state_reg.status[STOP_BIT])
        else $error("stop recovery response wrong");

    AST_READ_CLEARS: assert property (
        rd_ctl && !timeout_ev && !EXT_RESET_SEEN_IN |=> state_reg.status == 8'h00)
        else $error("control read did not clear status");

    AST_LOCKED_WRITE: assert property (
        wr && (sel_acc[1] || sel_acc[2] || sel_acc[3]) && state_reg.lock == LOCK_IDLE
        |=> $stable(state_reg.reload))
        else $error("reload changed while locked");

    AST_UNLOCK_NO_STATUS: assert property (
        wr && sel_acc[0] && !timeout_ev && !EXT_RESET_SEEN_IN |=> $stable(state_reg.status))
        else $error("control write changed status");

    AST_STOP_FREEZE: assert property (
        STOP_MODE_IN && state_reg.stop_disable |=> !RC_OSC_ENABLE_OUT && $stable(state_reg.count))
        else $error("watchdog ran in stop while disabled");

    AST_PREADY_PULSE: assert property (
        PSEL_IN && !PENABLE_IN
        |=> PREADY_OUT ##1 !PREADY_OUT)
        else $error("ready not a single pulse after setup");

    AST_SLVERR_UNMAPPED: assert property (
        PSEL_IN && !PENABLE_IN && sel_setup == 4'h0
        |=> PSLVERR_OUT && PREADY_OUT)
        else $error("unmapped address without slave error");

    AST_RDATA_HIGH_ZERO: assert property (
        PREADY_OUT |-> PRDATA_OUT[31:8] == 24'h000000)
        else $error("read data upper bits not zero");

    AST_OSC_DEFAULT: assert property (
        !state_reg.stop_disable |=> RC_OSC_ENABLE_OUT)
        else $error("oscillator disabled without stop-disable setting");

    AST_STOP_CODE: assert property (
        wr && sel_acc[0] && state_reg.lock == LOCK_OPEN && wbyte == STOP_OFF_CODE
        |=> state_reg.stop_disable)
        else $error("stop-disable code not taken after unlock");

    AST_RELOAD_UPPER: assert property (
        wr && sel_acc[1] && state_reg.lock == LOCK_OPEN
        |=> state_reg.reload[23:16] == $past(PWDATA_IN[7:0]))
        else $error("upper reload byte not stored after unlock");

    AST_TIMEOUT_AT_ZERO: assert property (
        timeout_ev |=> state_reg.count == 24'h000000)
        else $error("time-out without count reaching zero");

    AST_LOCK_FOREIGN: assert property (
        wr && state_reg.lock == LOCK_FIRST && !sel_acc[0]
        |=> state_reg.lock == LOCK_IDLE)
        else $error("foreign write did not reset the lock");

endmodule

//--- testbench/core_model.sv
// partner model: processor core, interrupt controller and reset logic of the watchdog
// assumes CLK_IN at 100 MHz; the oscillator pin runs unrelated to it
`timescale 1ns/1ps
module core_model (
    // clock
    input wire logic clk_in,
    // oscillator enable and time-out responses
    input wire logic osc_enable_in,
    input wire logic irq_in,
    input wire logic reset_req_in,
    input wire logic recovery_in,
    // oscillator pin and refresh instruction
    output logic rc_osc_out,
    output logic refresh_out
);
    int irq_count = 0;
    int rst_count = 0;
    int rec_count = 0;

    initial begin
        rc_osc_out = 1'b0;
        refresh_out = 1'b0;
    end

    always @(posedge clk_in) begin
        if (irq_in === 1'b1) irq_count++;
        if (reset_req_in === 1'b1) rst_count++;
        if (recovery_in === 1'b1) rec_count++;
    end

    // pin edges sit between clock edges so no sample races a change
    task automatic tick(input int n);
        #3;
        for (int i = 0; i < n; i++) begin
            if (osc_enable_in) begin
                rc_osc_out = 1'b1;
            end
            #55;
            rc_osc_out = 1'b0;
            #55;
        end
    endtask

    task automatic refresh();
        @(posedge clk_in);
        refresh_out <= 1'b1;
        @(posedge clk_in);
        refresh_out <= 1'b0;
    endtask
endmodule

//--- testbench/watchdog_downcounter_tb_top.sv
// self-checking bench: apb register access, refresh, time-out responses, lock
// assumes the core model drives the oscillator pin and the refresh pulse
`timescale 1ns/1ps
module watchdog_downcounter_tb_top
    import watchdog_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1;
    logic psel, penable, pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, rc_osc, osc_en, refresh;
    logic always_on, resp_rst, stop, debug, ext;
    logic irq, rst_req, recov;
    logic [31:0] rd;
    logic err;
    int n_errors = 0;
    int samples_checked = 0;

    always #5 clk = ~clk;

    watchdog_downcounter uut (.CLK_IN(clk), .RESET_IN(rst), .PSEL_IN(psel),
        .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
        .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
        .RC_OSC_IN(rc_osc), .RC_OSC_ENABLE_OUT(osc_en), .REFRESH_IN(refresh),
        .ALWAYS_ON_IN(always_on), .RESPONSE_RESET_IN(resp_rst), .STOP_MODE_IN(stop),
        .DEBUG_MODE_IN(debug), .EXT_RESET_SEEN_IN(ext), .TIMEOUT_IRQ_OUT(irq),
        .TIMEOUT_RESET_OUT(rst_req), .STOP_RECOVERY_OUT(recov));

    core_model core (.clk_in(clk), .osc_enable_in(osc_en), .irq_in(irq),
        .reset_req_in(rst_req), .recovery_in(recov), .rc_osc_out(rc_osc),
        .refresh_out(refresh));

    task automatic stop_test();
        $display("errors %0d, comparisons %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t data got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_flag(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t flag got %b exp %b", $time, got, exp);
        end
    endtask

    // byte address is four times the register index
    task automatic apb(input logic w, input logic [11:0] idx, input logic [7:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        // only the watchdog process ends a wait that never sees pready
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask

    task automatic rd_chk(input logic [11:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        chk_data(rd, {24'h000000, exp});
    endtask

    task automatic unlock();
        wr(CTL_INDEX, UNLOCK_FIRST);
        wr(CTL_INDEX, UNLOCK_SECOND);
    endtask

    initial begin
        #500000;
        n_errors++;
        stop_test();
    end

    initial begin
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= '0;
        pwdata <= '0;
        always_on <= 1'b0;
        resp_rst <= 1'b0;
        stop <= 1'b0;
        debug <= 1'b0;
        ext <= 1'b0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        core.tick(2);
        rd_chk(LOW_INDEX, 8'hff);
        rd_chk(CTL_INDEX, 8'h80);
        rd_chk(CTL_INDEX, 8'h00);
        apb(1'b0, 12'hff4, 8'h00);
        chk_flag(err, 1'b1);
        unlock();
        wr(UPPER_INDEX, 8'h00);
        wr(HIGH_INDEX, 8'h00);
        wr(LOW_INDEX, 8'h10);
        rd_chk(CTL_INDEX, 8'h00);
        core.refresh();
        rd_chk(LOW_INDEX, 8'h10);
        rd_chk(UPPER_INDEX, 8'h00);
        core.tick(3);
        rd_chk(LOW_INDEX, 8'h0d);
        core.refresh();
        rd_chk(LOW_INDEX, 8'h10);
        core.tick(14);
        core.refresh();
        rd_chk(LOW_INDEX, 8'h02);
        core.tick(2);
        chk_data(32'(core.irq_count), 32'h1);
        rd_chk(CTL_INDEX, 8'h20);
        core.tick(1);
        rd_chk(UPPER_INDEX, 8'hff);
        // a foreign write between unlock steps closes the lock again
        wr(CTL_INDEX, UNLOCK_FIRST);
        wr(HIGH_INDEX, 8'h00);
        wr(CTL_INDEX, UNLOCK_SECOND);
        wr(UPPER_INDEX, 8'h12);
        core.refresh();
        rd_chk(UPPER_INDEX, 8'h00);
        @(posedge clk);
        resp_rst <= 1'b1;
        core.tick(16);
        chk_data(32'(core.rst_count), 32'h1);
        chk_data(32'(core.irq_count), 32'h1);
        rd_chk(CTL_INDEX, 8'h20);
        core.tick(1);
        @(posedge clk);
        stop <= 1'b1;
        core.refresh();
        chk_flag(osc_en, 1'b1);
        core.tick(16);
        chk_data(32'(core.rec_count), 32'h1);
        rd_chk(CTL_INDEX, 8'h60);
        unlock();
        wr(CTL_INDEX, STOP_OFF_CODE);
        repeat (3) @(posedge clk);
        chk_flag(osc_en, 1'b0);
        unlock();
        wr(CTL_INDEX, STOP_ON_CODE);
        repeat (3) @(posedge clk);
        chk_flag(osc_en, 1'b1);
        stop <= 1'b0;
        unlock();
        wr(CTL_INDEX, STOP_OFF_CODE);
        repeat (3) @(posedge clk);
        chk_flag(osc_en, 1'b1);
        @(posedge clk);
        debug <= 1'b1;
        core.tick(20);
        rd_chk(LOW_INDEX, 8'h10);
        chk_data(32'(core.rst_count), 32'h1);
        @(posedge clk);
        ext <= 1'b1;
        @(posedge clk);
        ext <= 1'b0;
        rd_chk(CTL_INDEX, 8'h10);
        // second reset: the always-on option alone starts the count
        @(posedge clk);
        rst <= 1'b1;
        debug <= 1'b0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        always_on <= 1'b1;
        repeat (2) @(posedge clk);
        core.tick(1);
        rd_chk(LOW_INDEX, 8'hfe);
        rd_chk(CTL_INDEX, 8'h80);
        stop_test();
    end
endmodule
